// ---- hdl/radio_spi_slave_packet_buffer.v ----
// Serial slave transaction engine with direct registers and packet store access.
//
// What this block does
// - The serial slave works in every power state except reset.
// - Registers stay readable and writable while the oscillator is off.
// - Synchronous mode writes a register through a clock-enable pulse on the system clock.
// - Synchronous mode latches read data at the end of the control word and of each data byte.
// - Asynchronous mode takes its write strobe from the link; read data is not latched.
// - Oscillator-ready sampled on first serial clock picks the mode until the first serial clock of the next transaction.
// - Clearing the oscillator enable drops oscillator-ready as soon as the power-mode byte is written, inside that transfer.
// - No register is written after the power-mode register within a transfer.
// - Asynchronous mode persists until a transaction starts with oscillator-ready high.
// - Interrupt status register 0 is shifted out during every control word.
// - Multi-byte register reads start anywhere and return consecutive registers.
// - Packet store is 128 bytes; transmit length byte sits at location 0.
// - Device computes the two frame check bytes of a transmitted frame.
// - Received length has its own register; payload starts at location 0.
// - A quality byte follows the last received check byte.
// - Packet store reads are non-destructive.
// - Burst mode starts at location 0 and advances per data byte.
// - Byte mode takes its start location from the byte after the control word.
// - Any length is accepted; the location counter wraps from 127 to 0.
// - Control byte: bit 7 read, bit 6 store, bit 5 byte mode, low bits address.
// - Clock idles low, capture on rising edge, change on falling edge, MSB first.
// - Underrun is flagged only during burst reads of the packet store.
`timescale 1ns/1ps
`include "radio_spi_defines.vh"
module radio_spi_slave_packet_buffer #(
  parameter STORE_AW = 7
) (
  input  wire        clk,
  input  wire        rstn,
  input  wire        sclk,
  input  wire        ssel_n,
  input  wire        mosi,
  output reg         miso,
  output wire        miso_oe_n,
  input  wire        xtal_ready,
  output wire        oscillator_enable,
  output reg         sync_mode,
  output reg         reg_write_enable,
  output reg         reg_write_link_clock,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o
);

  // ****************************************************************
  // Pin synchronisers and edge detection
  // ****************************************************************
  reg [2:0] sclk_p;
  reg [2:0] ssel_p;
  reg [1:0] mosi_p;
  reg [1:0] xtal_p;

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sclk_p <= 3'h0;
      ssel_p <= 3'h7;
      mosi_p <= 2'h0;
      xtal_p <= 2'h0;
    end
    else
    begin
      sclk_p <= {sclk_p[1:0], sclk};
      ssel_p <= {ssel_p[1:0], ssel_n};
      mosi_p <= {mosi_p[0], mosi};
      xtal_p <= {xtal_p[0], xtal_ready};
    end
  end

  wire sclk_rise = sclk_p[1] & ~sclk_p[2];
  wire sclk_fall = ~sclk_p[1] & sclk_p[2];
  wire active    = ~ssel_p[1];
  wire sel_start = ~ssel_p[1] & ssel_p[2];
  wire mosi_bit  = mosi_p[1];

  // ****************************************************************
  // Register state and decoding
  // ****************************************************************
  reg [7:0]          reg_mem [0:63];
  reg [7:0]          rx_length;
  reg [7:0]          power_mode;
  reg                rx_busy;
  reg                underrun;
  reg [STORE_AW-1:0] bus_ptr;
  reg [15:0]         fcs;

  assign oscillator_enable = power_mode[`OSC_ENABLE_BIT];
  wire   xtal_eff          = xtal_p[1] & power_mode[`OSC_ENABLE_BIT];

  function [7:0] reg_value;
    input [5:0] addr;
    begin
      if (addr == `REG_RX_LENGTH)
        reg_value = rx_length;
      else if (addr == `REG_POWER_MODE)
        reg_value = power_mode;
      else
        reg_value = reg_mem[addr];
    end
  endfunction

  function [15:0] fcs_byte;
    input [15:0] c;
    input [7:0]  d;
    integer      i;
    reg   [15:0] r;
    reg          fb;
    begin
      r = c;
      for (i = 0; i < 8; i = i + 1)
      begin
        fb = r[0] ^ d[i];
        r  = {1'b0, r[15:1]};
        if (fb)
          r = r ^ `FCS_POLY;
      end
      fcs_byte = r;
    end
  endfunction

  // ****************************************************************
  // Serial transaction engine
  // ****************************************************************
  reg [1:0]          phase;
  reg [2:0]          bit_cnt;
  reg [6:0]          rx_shift;
  reg [7:0]          tx_shift;
  reg [7:0]          ctrl;
  reg [5:0]          reg_addr;
  reg [STORE_AW-1:0] ptr;
  reg                first_bit;
  reg                load_next;
  reg                stop_wr;
  reg [7:0]          rd_hold;

  wire [7:0]    rx_byte   = {rx_shift, mosi_bit};
  wire          byte_done = active & sclk_rise & (bit_cnt == 3'h7);
  wire          is_read   = ctrl[`CW_DIR_BIT];
  wire          is_store  = ctrl[`CW_TARGET_BIT];
  wire          byte_mode = ctrl[`CW_MODE_BIT];
  wire [7:0]    store_a_rdata;
  wire [7:0]    store_b_rdata;
  wire          in_data   = (phase == `PH_DATA);
  wire          read_load = load_next & sclk_fall & active & in_data & is_read;
  wire          reg_wr    = byte_done & in_data & ~is_read & ~is_store & ~stop_wr;
  wire          store_we  = byte_done & in_data & ~is_read & is_store;
  wire          underrun_set = read_load & is_store & ~byte_mode & rx_busy
                               & (ptr >= bus_ptr);
  wire [7:0]    live_value = reg_value(reg_addr);
  wire [7:0]    next_tx   = is_store ? store_a_rdata
                            : (sync_mode ? rd_hold : live_value);

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      phase     <= `PH_CTRL;
      bit_cnt   <= 3'h0;
      rx_shift  <= 7'h00;
      tx_shift  <= 8'h00;
      ctrl      <= 8'h00;
      reg_addr  <= 6'h00;
      ptr       <= {STORE_AW{1'b0}};
      first_bit <= 1'b0;
      load_next <= 1'b0;
      stop_wr   <= 1'b0;
      rd_hold   <= 8'h00;
      sync_mode <= 1'b0;
      miso      <= 1'b0;
    end
    else if (!active)
    begin
      phase     <= `PH_CTRL;
      bit_cnt   <= 3'h0;
      ptr       <= {STORE_AW{1'b0}};
      load_next <= 1'b0;
      stop_wr   <= 1'b0;
      first_bit <= 1'b0;
      miso      <= 1'b0;
    end
    else if (sel_start)
    begin
      tx_shift  <= reg_value(`REG_IRQ_STATUS);
      miso      <= reg_mem[`REG_IRQ_STATUS][7];
      first_bit <= 1'b1;
    end
    else
    begin
      if (sclk_rise)
      begin
        rx_shift <= rx_byte[6:0];
        bit_cnt  <= bit_cnt + 3'h1;
        if (first_bit)
        begin
          sync_mode <= xtal_eff;
          first_bit <= 1'b0;
        end
      end
      if (byte_done)
      begin
        load_next <= 1'b1;
        case (phase)
          `PH_CTRL:
          begin
            ctrl     <= rx_byte;
            reg_addr <= rx_byte[`CW_ADDR_MSB:0];
            rd_hold  <= reg_value(rx_byte[`CW_ADDR_MSB:0]);
            ptr      <= {STORE_AW{1'b0}};
            if (rx_byte[`CW_TARGET_BIT] && rx_byte[`CW_MODE_BIT])
              phase <= `PH_ADDR;
            else
              phase <= `PH_DATA;
          end
          `PH_ADDR:
          begin
            ptr   <= rx_byte[STORE_AW-1:0];
            phase <= `PH_DATA;
          end
          `PH_DATA:
          begin
            if (is_read && !is_store)
              rd_hold <= live_value;
            if (!is_read && !is_store)
            begin
              reg_addr <= reg_addr + 6'h01;
              if (reg_addr == `REG_POWER_MODE)
                stop_wr <= 1'b1;
            end
            if (!is_read && is_store)
              ptr <= ptr + 1'b1;
          end
          default:
            phase <= `PH_CTRL;
        endcase
      end
      if (sclk_fall)
      begin
        if (load_next)
        begin
          load_next <= 1'b0;
          tx_shift  <= read_load ? next_tx : 8'h00;
          miso      <= read_load ? next_tx[7] : 1'b0;
          if (read_load && is_store)
            ptr <= ptr + 1'b1;
          if (read_load && !is_store)
            reg_addr <= reg_addr + 6'h01;
        end
        else
        begin
          tx_shift <= {tx_shift[6:0], 1'b0};
          miso     <= tx_shift[6];
        end
      end
    end
  end

  assign miso_oe_n = ~active;

  // ****************************************************************
  // Register write strobes and direct register storage
  // ****************************************************************
  wire wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr  = wb_hit & wb_we_i & wb_sel_i[0];

  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      reg_write_enable     <= 1'b0;
      reg_write_link_clock <= 1'b0;
      power_mode           <= `POWER_RESET;
    end
    else
    begin
      reg_write_enable     <= reg_wr & sync_mode;
      reg_write_link_clock <= reg_wr & ~sync_mode;
      if (reg_wr && reg_addr == `REG_POWER_MODE)
        power_mode <= rx_byte;
    end
  end

  always @(posedge clk)
  begin
    if (reg_wr)
      reg_mem[reg_addr] <= rx_byte;
    else if (wb_wr && wb_adr_i == `WB_IRQ_STATUS)
      reg_mem[`REG_IRQ_STATUS] <= wb_dat_i[7:0];
  end

  // ****************************************************************
  // Packet store
  // ****************************************************************
  wire bus_store_we = wb_wr & (wb_adr_i == `WB_STORE);

  packet_store #(
    .DW (8),
    .AW (STORE_AW)
  ) u_store (
    .clk     (clk),
    .a_addr  (ptr),
    .a_we    (store_we),
    .a_wdata (rx_byte),
    .a_rdata (store_a_rdata),
    .b_addr  (bus_ptr),
    .b_we    (bus_store_we),
    .b_wdata (wb_dat_i[7:0]),
    .b_rdata (store_b_rdata)
  );

  // ****************************************************************
  // Wishbone slave for the radio core side
  // ****************************************************************
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wb_ack_o  <= 1'b0;
      wb_dat_o  <= 32'h00000000;
      rx_length <= `REG_RESET;
      rx_busy   <= 1'b0;
      underrun  <= 1'b0;
      bus_ptr   <= {STORE_AW{1'b0}};
      fcs       <= `FCS_INIT;
    end
    else
    begin
      wb_ack_o <= wb_hit;
      if (underrun_set)
        underrun <= 1'b1;
      else if (wb_wr && wb_adr_i == `WB_CONTROL && wb_dat_i[`CTL_UNDERRUN])
        underrun <= 1'b0;
      if (wb_hit)
      begin
        wb_dat_o <= 32'h00000000;
        case (wb_adr_i)
          `WB_IRQ_STATUS:
            wb_dat_o[7:0] <= reg_mem[`REG_IRQ_STATUS];
          `WB_RX_LENGTH:
          begin
            wb_dat_o[7:0] <= rx_length;
            if (wb_wr)
              rx_length <= wb_dat_i[7:0];
          end
          `WB_CONTROL:
          begin
            wb_dat_o[`CTL_RX_BUSY]    <= rx_busy;
            wb_dat_o[`CTL_UNDERRUN]   <= underrun;
            wb_dat_o[`CTL_SYNC_MODE]  <= sync_mode;
            wb_dat_o[`CTL_XTAL_READY] <= xtal_eff;
            if (wb_wr)
              rx_busy <= wb_dat_i[`CTL_RX_BUSY];
          end
          `WB_POINTER:
          begin
            wb_dat_o[STORE_AW-1:0] <= bus_ptr;
            if (wb_wr)
            begin
              bus_ptr <= wb_dat_i[STORE_AW-1:0];
              fcs     <= `FCS_INIT;
            end
          end
          `WB_STORE:
            if (wb_wr)
              bus_ptr <= bus_ptr + 1'b1;
          `WB_FETCH:
            if (!wb_we_i)
            begin
              wb_dat_o[7:0] <= store_b_rdata;
              bus_ptr       <= bus_ptr + 1'b1;
              fcs           <= fcs_byte(fcs, store_b_rdata);
            end
          `WB_FCS:
            wb_dat_o[15:0] <= fcs;
          default:
            wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

// ---- hdl/radio_spi_defines.vh ----
// Constants shared by the serial slave engine and its packet store.
`ifndef RADIO_SPI_DEFINES_VH
`define RADIO_SPI_DEFINES_VH

// ****************************************************************
// Control word layout
// ****************************************************************
`define CW_DIR_BIT      7
`define CW_TARGET_BIT   6
`define CW_MODE_BIT     5
`define CW_ADDR_MSB     5

// ****************************************************************
// Direct register space
// ****************************************************************
`define REG_IRQ_STATUS  6'h00
`define REG_RX_LENGTH   6'h01
`define REG_POWER_MODE  6'h3F
`define OSC_ENABLE_BIT  0
`define POWER_RESET     8'h01
`define REG_RESET       8'h00

// ****************************************************************
// Transaction phases
// ****************************************************************
`define PH_CTRL         2'h0
`define PH_ADDR         2'h1
`define PH_DATA         2'h2

// ****************************************************************
// Wishbone register offsets and control fields
// ****************************************************************
`define WB_IRQ_STATUS   8'h00
`define WB_RX_LENGTH    8'h04
`define WB_CONTROL      8'h08
`define WB_POINTER      8'h0C
`define WB_STORE        8'h10
`define WB_FETCH        8'h14
`define WB_FCS          8'h18
`define CTL_RX_BUSY     0
`define CTL_UNDERRUN    1
`define CTL_SYNC_MODE   2
`define CTL_XTAL_READY  3

// ****************************************************************
// Frame check sequence
// ****************************************************************
`define FCS_POLY        16'h8408
`define FCS_INIT        16'h0000

`endif

// ---- hdl/packet_store.v ----
// Byte-addressable packet store with a serial-side port and a bus-side port.
`timescale 1ns/1ps
module packet_store #(
  parameter DW = 8,
  parameter AW = 7
) (
  input  wire          clk,
  input  wire [AW-1:0] a_addr,
  input  wire          a_we,
  input  wire [DW-1:0] a_wdata,
  output reg  [DW-1:0] a_rdata,
  input  wire [AW-1:0] b_addr,
  input  wire          b_we,
  input  wire [DW-1:0] b_wdata,
  output reg  [DW-1:0] b_rdata
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  // Reads never alter contents; the serial port wins a same-cycle write clash.
  always @(posedge clk)
  begin
    if (b_we)
      mem[b_addr] <= b_wdata;
    if (a_we)
      mem[a_addr] <= a_wdata;
    a_rdata <= mem[a_addr];
    b_rdata <= mem[b_addr];
  end

endmodule

// ---- tb/radio_spi_checker.sv ----
// Port-level assertions for the serial slave engine.
`timescale 1ns/1ps
module radio_spi_checker #(
  parameter STORE_AW = 7
) (
  input wire clk,
  input wire rstn,
  input wire ssel_n,
  input wire miso_oe_n,
  input wire xtal_ready,
  input wire oscillator_enable,
  input wire sync_mode,
  input wire reg_write_enable,
  input wire reg_write_link_clock,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o
);
  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb
    @(posedge clk);
  endclocking
  default disable iff (!rstn);

  ack_once_a:
  assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("bus request not answered in one cycle");
  ack_drop_a:
  assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus acknowledge longer than one cycle");
  oe_on_a:
  assert property ($fell(ssel_n) |-> ##[1:4] !miso_oe_n)
    else $error("data output not enabled after select");
  oe_off_a:
  assert property (ssel_n [*4] |-> miso_oe_n)
    else $error("data output driven while deselected");
  sync_strobe_a:
  assert property (reg_write_enable |-> sync_mode)
    else $error("clock-enable write outside synchronous mode");
  async_strobe_a:
  assert property (reg_write_link_clock |-> !sync_mode)
    else $error("link-clocked write inside synchronous mode");
  strobe_pulse_a:
  assert property ((reg_write_enable || reg_write_link_clock) |=>
                   !(reg_write_enable || reg_write_link_clock))
    else $error("register write strobe longer than one cycle");
  quiet_idle_a:
  assert property (ssel_n [*8] |-> !reg_write_enable && !reg_write_link_clock)
    else $error("register write while deselected");
  sync_rise_a:
  assert property ($rose(sync_mode) |-> xtal_ready && oscillator_enable)
    else $error("synchronous mode entered without ready oscillator");
  osc_drop_a:
  assert property ($fell(oscillator_enable) |-> !ssel_n)
    else $error("oscillator enable fell outside a transfer");
endmodule

bind radio_spi_slave_packet_buffer radio_spi_checker #(.STORE_AW(STORE_AW)) i_checker (
  .clk(clk), .rstn(rstn), .ssel_n(ssel_n), .miso_oe_n(miso_oe_n),
  .xtal_ready(xtal_ready), .oscillator_enable(oscillator_enable), .sync_mode(sync_mode),
  .reg_write_enable(reg_write_enable), .reg_write_link_clock(reg_write_link_clock),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o)
);

// ---- tb/host_spi_master.sv ----
// Host-side serial master model driving select, clock and data.
`timescale 1ns/1ps
module host_spi_master (
  output reg  sclk,
  output reg  ssel_n,
  output reg  mosi,
  input  wire miso,
  input  wire miso_oe_n
);
  // The data line has a pull-up, so a released line reads high.
  wire line = miso_oe_n ? 1'b1 : miso;

  initial
  begin
    sclk = 1'b0;
    ssel_n = 1'b1;
    mosi = 1'b1;
  end

  task open_frame;
    begin
      #7;
      ssel_n = 1'b0;
      #240;
    end
  endtask

  // Sends the top nbits of tx and samples the reply at each rising clock edge.
  task shift(input [7:0] tx, input integer nbits, output [7:0] rx);
    integer i;
    begin
      rx = 8'h00;
      for (i = 7; i > 7 - nbits; i = i - 1)
      begin
        mosi = tx[i];
        #160 sclk = 1'b1;
        rx[i] = line;
        #160 sclk = 1'b0;
      end
    end
  endtask

  // The clock stands still between frames and the data line stops showing the last bit.
  task close_frame;
    begin
      #320 ssel_n = 1'b1;
      mosi = ~mosi;
      #320;
    end
  endtask
endmodule

// ---- tb/radio_spi_slave_packet_buffer_test.sv ----
// Self-checking bench for the serial slave engine and its packet store.
`timescale 1ns/1ps
`include "radio_spi_defines.vh"
module radio_spi_slave_packet_buffer_test;
  typedef struct packed { logic [7:0] adr; logic [7:0] dat; } row_t;
  row_t       rows [0:3] = '{'{8'h05, 8'h21}, '{8'h02, 8'hA5}, '{8'h10, 8'h3C},
                             '{8'h3E, 8'hFF}};
  reg         clk = 1'b0;
  reg         rstn = 1'b0;
  reg         xtal_ready = 1'b1;
  reg         wb_cyc = 1'b0;
  reg         wb_stb = 1'b0;
  reg         wb_we = 1'b0;
  reg  [3:0]  wb_sel = 4'hF;
  reg  [7:0]  wb_adr = 8'h00;
  reg  [31:0] wb_dat = 32'h00000000;
  reg  [31:0] q;
  reg  [15:0] crc;
  reg  [7:0]  tx [0:7];
  reg  [7:0]  rx [0:7];
  wire [31:0] wb_dat_o;
  wire        wb_ack, sclk, ssel_n, mosi, miso, miso_oe_n, osc_en, sync_mode;
  integer     fails = 0;
  integer     n_tests = 0;
  integer     r, i;

  always #20 clk = ~clk;

  radio_spi_slave_packet_buffer i_dut (
    .clk(clk), .rstn(rstn), .sclk(sclk), .ssel_n(ssel_n), .mosi(mosi), .miso(miso),
    .miso_oe_n(miso_oe_n), .xtal_ready(xtal_ready), .oscillator_enable(osc_en),
    .sync_mode(sync_mode), .reg_write_enable(), .reg_write_link_clock(),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack)
  );
  host_spi_master i_host (
    .sclk(sclk), .ssel_n(ssel_n), .mosi(mosi), .miso(miso), .miso_oe_n(miso_oe_n)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp)
      begin
        fails = fails + 1;
        $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
      end
    end
  endtask

  task wb(input we, input [7:0] adr, input [31:0] dat);
    begin
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_dat <= dat;
      @(posedge clk);
      while (wb_ack !== 1'b1)
        @(posedge clk);
      q = wb_dat_o;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge clk);
    end
  endtask

  task put(input [7:0] a, input [7:0] b, input [7:0] c, input [7:0] d);
    begin
      tx[0] = a;
      tx[1] = b;
      tx[2] = c;
      tx[3] = d;
    end
  endtask

  task spi(input integer n);
    integer j;
    begin
      i_host.open_frame;
      for (j = 0; j < n; j = j + 1)
        i_host.shift(tx[j], 8, rx[j]);
      i_host.close_frame;
      @(posedge clk);
    end
  endtask

  function [15:0] fcs(input [15:0] c, input [7:0] d);
    integer k;
    begin
      fcs = c ^ {8'h00, d};
      for (k = 0; k < 8; k = k + 1)
        fcs = fcs[0] ? ((fcs >> 1) ^ `FCS_POLY) : (fcs >> 1);
    end
  endfunction

  task end_of_test;
    begin
      $display("Checks made: %0d, mismatches: %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask

  initial
  begin
    #1000000;
    fails = fails + 1;
    $display("MISMATCH at %0t: watchdog expired", $time);
    end_of_test;
  end

  // ****************************************************************
  // Stimulus
  // ****************************************************************
  initial
  begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    wb(1'b1, `WB_IRQ_STATUS, 32'h0000005A);
    for (r = 0; r < 4; r = r + 1)
    begin
      put({2'b00, rows[r].adr[5:0]}, rows[r].dat, 8'h00, 8'h00);
      spi(2);
      put({2'b10, rows[r].adr[5:0]}, 8'h00, 8'h00, 8'h00);
      spi(2);
      chk(rx[0], 8'h5A);
      chk(rx[1], rows[r].dat);
    end
    wb(1'b1, `WB_RX_LENGTH, 32'h00000021);
    wb(1'b0, `WB_RX_LENGTH, 32'h00000000);
    chk(q[7:0], 8'h21);
    put(8'h02, 8'hB2, 8'hB3, 8'h00);
    spi(3);
    put(8'h81, 8'h00, 8'h00, 8'h00);
    spi(4);
    chk(rx[0], 8'h5A);
    chk(rx[1], 8'h21);
    chk(rx[2], 8'hB2);
    chk(rx[3], 8'hB3);
    put(8'h40, 8'hD0, 8'hD1, 8'hD2);
    tx[4] = 8'hD3;
    spi(5);
    put(8'hC0, 8'h00, 8'h00, 8'h00);
    spi(5);
    wb(1'b1, `WB_POINTER, 32'h00000000);
    for (i = 0; i < 4; i = i + 1)
    begin
      wb(1'b0, `WB_FETCH, 32'h00000000);
      chk(q[7:0], 8'hD0 + i[7:0]);
      chk(rx[i + 1], 8'hD0 + i[7:0]);
    end
    put(8'h60, 8'h7F, 8'hE1, 8'hE2);
    spi(4);
    put(8'hE0, 8'h7F, 8'h00, 8'h00);
    spi(4);
    chk(rx[2], 8'hE1);
    chk(rx[3], 8'hE2);
    wb(1'b1, `WB_POINTER, 32'h00000000);
    wb(1'b0, `WB_FETCH, 32'h00000000);
    chk(q[7:0], 8'hE2);
    crc = fcs(`FCS_INIT, 8'hE2);
    wb(1'b0, `WB_FETCH, 32'h00000000);
    chk(q[7:0], 8'hD1);
    crc = fcs(crc, 8'hD1);
    wb(1'b0, `WB_FCS, 32'h00000000);
    chk(q[7:0], crc[7:0]);
    chk(q[15:8], crc[15:8]);
    wb(1'b1, `WB_CONTROL, 32'h00000001);
    wb(1'b1, `WB_POINTER, 32'h00000002);
    put(8'hE0, 8'h05, 8'h00, 8'h00);
    spi(3);
    wb(1'b0, `WB_CONTROL, 32'h00000000);
    chk({7'h00, q[1]}, 8'h00);
    put(8'hC0, 8'h00, 8'h00, 8'h00);
    spi(5);
    wb(1'b0, `WB_CONTROL, 32'h00000000);
    chk({7'h00, q[1]}, 8'h01);
    wb(1'b1, `WB_CONTROL, 32'h00000002);
    wb(1'b0, `WB_CONTROL, 32'h00000000);
    chk({6'h00, q[1:0]}, 8'h00);
    xtal_ready <= 1'b0;
    put(8'h82, 8'h00, 8'h00, 8'h00);
    spi(2);
    chk({7'h00, sync_mode}, 8'h00);
    chk(rx[1], 8'hB2);
    xtal_ready <= 1'b1;
    spi(2);
    chk({7'h00, sync_mode}, 8'h01);
    put(8'h3F, 8'h00, 8'h77, 8'h00);
    spi(3);
    chk({7'h00, osc_en}, 8'h00);
    wb(1'b0, `WB_IRQ_STATUS, 32'h00000000);
    chk(q[7:0], 8'h5A);
    put(8'h82, 8'h00, 8'h00, 8'h00);
    spi(2);
    chk({7'h00, sync_mode}, 8'h00);
    chk(rx[1], 8'hB2);
    put(8'h3F, 8'h01, 8'h00, 8'h00);
    spi(2);
    chk({7'h00, osc_en}, 8'h01);
    put(8'h82, 8'h00, 8'h00, 8'h00);
    spi(2);
    chk({7'h00, sync_mode}, 8'h01);
    i_host.open_frame;
    i_host.shift(8'h82, 3, rx[0]);
    i_host.close_frame;
    @(posedge clk);
    spi(2);
    chk(rx[1], 8'hB2);
    rstn <= 1'b0;
    @(posedge clk);
    #1;
    chk({5'h00, osc_en, miso_oe_n, sync_mode}, 8'h06);
    @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    wb(1'b0, `WB_RX_LENGTH, 32'h00000000);
    chk(q[7:0], 8'h00);
    spi(2);
    chk(rx[0], 8'h5A);
    chk(rx[1], 8'hB2);
    wb(1'b0, 8'h40, 32'h00000000);
    chk(q[7:0], 8'h00);
    end_of_test;
  end
endmodule
